// ---- flash_protect_cfg.svh ----
`ifndef FLASH_PROTECT_CFG_SVH
`define FLASH_PROTECT_CFG_SVH

// register offsets on the plain register port
`define ADDR_PFLASH_PROT      4'h0
`define ADDR_DFLASH_PROT      4'h1
`define ADDR_STATUS           4'h2
`define ADDR_CMD_INDEX        4'h3
`define ADDR_CMD_HI           4'h4
`define ADDR_CMD_LO           4'h5
`define ADDR_CHECK_CTRL       4'h6
`define ADDR_CHECK_ADDR_HI    4'h7
`define ADDR_CHECK_ADDR_MID   4'h8
`define ADDR_CHECK_ADDR_LO    4'h9
`define ADDR_CHECK_RESULT     4'hA

// program-flash protection field positions
`define PF_MODE_BIT           7
`define PF_RNV_BIT            6
`define PF_HDIS_BIT           5
`define PF_HSIZE_MSB          4
`define PF_HSIZE_LSB          3
`define PF_LDIS_BIT           2
`define PF_LSIZE_MSB          1
`define PF_LSIZE_LSB          0

// data-flash protection field positions
`define DF_DIS_BIT            7
`define DF_SIZE_MSB           3
`define DF_SIZE_LSB           0

// status and check control bit positions
`define STAT_VIOL_BIT         5
`define CHK_GO_BIT            0
`define CHK_DFLASH_BIT        1
`define CHK_BLOCK_BIT         2

// fail-safe values on a double-bit fault, and the register reset value
`define PF_FAILSAFE           8'h7F
`define DF_FAILSAFE           8'h0F
`define REG_RESET             8'h00

// configuration byte addresses in program flash
`define CFG_ADDR_PFLASH       18'h3FF0C
`define CFG_ADDR_DFLASH       18'h3FF0D

// flash address map
`define PF_TOP                18'h3FFFF
`define PF_BASE               18'h38000
`define DF_BASE               18'h04400
`define HIGH_MIN_SHIFT        11
`define LOW_MIN_SHIFT         10
`define DF_STEP_SHIFT         8

// command object geometry
`define CMD_WORDS             6
`define CMD_IDX_W             3

`endif

// ---- flash_protect_pkg.sv ----
package flash_protect_pkg;

    typedef enum logic [1:0] {
        LOAD_PFLASH,
        LOAD_DFLASH,
        LOAD_DONE
    } load_state_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_type;

    typedef struct packed {
        logic        valid;
        logic [17:0] addr;
        logic [7:0]  data;
        logic        dbit_fault;
    } cfg_read_type;

endpackage : flash_protect_pkg

// ---- flash_protection_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_cfg.svh"

module flash_protection_checker (
    input wire logic                            mclk,
    input wire logic                            nrst,
    input wire logic [3:0]                      reg_addr,
    input wire logic [7:0]                      reg_wdata,
    input wire logic                            reg_wr,
    input wire logic                            reg_rd,
    input wire logic [7:0]                      reg_rdata,
    input wire flash_protect_pkg::cfg_read_type cfg_read,
    input wire logic [17:0]                     cfg_addr,
    input wire logic                            cfg_req,
    input wire logic                            load_done,
    input wire logic                            check_refused,
    input wire logic                            protect_violation_flag
);
    logic go_wr;
    logic clr_wr;

    // decoded bus events that cause refusals and flag clears
    assign go_wr  = reg_wr && reg_addr == `ADDR_CHECK_CTRL && reg_wdata[`CHK_GO_BIT];
    assign clr_wr = reg_wr && reg_addr == `ADDR_STATUS && reg_wdata[`STAT_VIOL_BIT];

    default clocking dflt @(posedge mclk); endclocking
    default disable iff (!nrst);

    // refusal and violation flag behaviour
    chk_refused_pulse: assert property (check_refused |=> !check_refused)
        else $error("refusal pulse longer than one cycle");
    chk_refuse_flags: assert property (check_refused |-> protect_violation_flag)
        else $error("refusal without violation flag");
    chk_refuse_cause: assert property (check_refused |-> $past(go_wr, 2))
        else $error("refusal without a check request two cycles before");
    chk_flag_cause: assert property ($rose(protect_violation_flag) |-> check_refused)
        else $error("violation flag rose without a refusal");
    chk_flag_sticky: assert property (protect_violation_flag && !clr_wr |=> protect_violation_flag)
        else $error("violation flag dropped without a clear");
    chk_flag_clears: assert property (clr_wr && load_done && !$past(go_wr) |=> !protect_violation_flag)
        else $error("violation flag not cleared");
    // configuration load sequence
    chk_cfg_where: assert property (cfg_req |-> cfg_addr == `CFG_ADDR_PFLASH || cfg_addr == `CFG_ADDR_DFLASH)
        else $error("configuration request at a wrong address");
    chk_done_cause: assert property ($rose(load_done) |-> $past(cfg_read.valid) || $past(cfg_read.valid, 2))
        else $error("load done without a configuration answer");
    chk_done_stays: assert property (load_done |=> load_done)
        else $error("load done dropped outside reset");
    chk_done_quiet: assert property (load_done |-> !cfg_req)
        else $error("configuration request after load");
    chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the read cycle");

    // main scenarios reached
    cov_refused: cover property (check_refused);
    cov_loaded: cover property ($rose(load_done));
    cov_cleared: cover property (clr_wr && protect_violation_flag);
endmodule : flash_protection_checker

bind flash_protection_control flash_protection_checker u_checker (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_read(cfg_read), .cfg_addr(cfg_addr),
    .cfg_req(cfg_req), .load_done(load_done), .check_refused(check_refused),
    .protect_violation_flag(protect_violation_flag)
);
`default_nettype wire

// ---- flash_protection_control.sv ----
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_cfg.svh"

// Function
// (R1) mode set: disable bits select protected ranges
// (R2) mode clear: disable bits select unprotected ranges
// (R3) high size codes give 2 to 16 kByte
// (R4) low size codes give 1 to 8 kByte
// (R5) program protection loaded from configuration at reset
// (R6) disallowed scenario writes ignored entirely
// (R7) scenario transition table enforced
// (R8) reads return scenario in force
// (R9) data size writes only increase
// (R10) data disable bit only clears
// (R11) disable set ignores data size
// (R12) data protection loaded from configuration at reset
// (R13) double fault gives full data protection
// (R14) protected program or erase sets violation
// (R15) data block erase refused if protected
// (R16) bit seven disables data protection
// (R17) data region is code plus one pages
// (R18) six indexed command words, byte access
// (R19) scenario is mode, high, low bits
// (R20) program protection register bit layout
// (R21) size fields writable only when disabled
// (R22) double fault gives full program protection
// (R23) program violations flagged, block erase refused
module flash_protection_control (
    input  wire logic                         mclk,
    input  wire logic                         nrst,
    input  wire logic [3:0]                   reg_addr,
    input  wire logic [7:0]                   reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [7:0]                   reg_rdata,
    input  wire flash_protect_pkg::cfg_read_type cfg_read,
    output logic      [17:0]                  cfg_addr,
    output logic                              cfg_req,
    output logic                              load_done,
    output logic                              check_refused,
    output logic                              protect_violation_flag
);

    typedef struct packed {
        logic                            done;
        flash_protect_pkg::load_state_type load;
        logic                            cfg_req;
        logic [17:0]                     cfg_addr;
        logic [7:0]                      pflash;
        logic [7:0]                      dflash;
        logic                            viol;
        logic [`CMD_IDX_W-1:0]           index;
        logic [`CMD_WORDS-1:0][15:0]     cmd;
        logic [2:0]                      chk_ctrl;
        logic [17:0]                     chk_addr;
        logic                            refused;
        logic [7:0]                      rdata;
    } state_type;

    state_type q;
    state_type d;

    logic [1:0]  rst_sync_q;
    logic        rst_n;
    logic        pf_hit;
    logic        pf_any;
    logic [2:0]  cur_scn;
    logic [2:0]  new_scn;
    logic [7:0]  pf_cand;
    logic        allowed;
    logic        df_hit;
    logic        df_any;
    logic [17:0] df_end;
    logic        refuse;

    flash_protect_pkg::bus_req_type req;

    // reset released through two flip-flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    pflash_range_check u_pcheck (
        .prot_reg      (q.pflash),
        .addr          (q.chk_addr),
        .protected_hit (pf_hit),
        .any_protected (pf_any)
    );

    // transition table lookup
    function automatic logic scn_allowed(input logic [2:0] from_s, input logic [2:0] to_s);
        logic [7:0] row;
        row = 8'h00;
        unique case (from_s)
            3'h0: row = 8'h0F;
            3'h1: row = 8'h0A;
            3'h2: row = 8'h0C;
            3'h3: row = 8'h08;
            3'h4: row = 8'h18;
            3'h5: row = 8'h3C;
            3'h6: row = 8'h5A;
            3'h7: row = 8'hFF;
        endcase
        return row[to_s];
    endfunction : scn_allowed

    // protection checks and next state
    always_comb begin
        d = q;
        d.rdata = 8'h00;
        d.refused = 1'b0;
        // (R19) scenario numbering
        cur_scn = {q.pflash[`PF_MODE_BIT], q.pflash[`PF_HDIS_BIT], q.pflash[`PF_LDIS_BIT]};
        // (R20) (R21) size fields held unless range disabled
        pf_cand = q.pflash;
        pf_cand[`PF_MODE_BIT] = req.wdata[`PF_MODE_BIT];
        pf_cand[`PF_HDIS_BIT] = req.wdata[`PF_HDIS_BIT];
        pf_cand[`PF_LDIS_BIT] = req.wdata[`PF_LDIS_BIT];
        if (q.pflash[`PF_HDIS_BIT]) begin
            pf_cand[`PF_HSIZE_MSB:`PF_HSIZE_LSB] = req.wdata[`PF_HSIZE_MSB:`PF_HSIZE_LSB];
        end
        if (q.pflash[`PF_LDIS_BIT]) begin
            pf_cand[`PF_LSIZE_MSB:`PF_LSIZE_LSB] = req.wdata[`PF_LSIZE_MSB:`PF_LSIZE_LSB];
        end
        new_scn = {pf_cand[`PF_MODE_BIT], pf_cand[`PF_HDIS_BIT], pf_cand[`PF_LDIS_BIT]};
        // (R7) transition table
        allowed = scn_allowed(cur_scn, new_scn);
        // (R17) data region end
        df_end = `DF_BASE
            + ({14'h0000, q.dflash[`DF_SIZE_MSB:`DF_SIZE_LSB]} + 18'h00001 << `DF_STEP_SHIFT);
        // (R11) (R16) disable bit overrides size
        df_any = !q.dflash[`DF_DIS_BIT];
        df_hit = df_any && (q.chk_addr >= `DF_BASE) && (q.chk_addr < df_end);
        // (R14) (R15) (R23) refuse protected targets and block erases
        if (q.chk_ctrl[`CHK_DFLASH_BIT]) begin
            refuse = q.chk_ctrl[`CHK_BLOCK_BIT] ? df_any : df_hit;
        end else begin
            refuse = q.chk_ctrl[`CHK_BLOCK_BIT] ? pf_any : pf_hit;
        end

        // configuration load sequence
        d.cfg_req = 1'b0;
        unique case (q.load)
            flash_protect_pkg::LOAD_PFLASH: begin
                d.cfg_req  = 1'b1;
                d.cfg_addr = `CFG_ADDR_PFLASH;
                if (q.cfg_req && cfg_read.valid) begin
                    // (R5) (R22) load or fail safe
                    d.pflash = cfg_read.dbit_fault ? `PF_FAILSAFE : cfg_read.data;
                    d.load = flash_protect_pkg::LOAD_DFLASH;
                    d.cfg_req = 1'b0;
                end
            end
            flash_protect_pkg::LOAD_DFLASH: begin
                d.cfg_req  = 1'b1;
                d.cfg_addr = `CFG_ADDR_DFLASH;
                if (q.cfg_req && cfg_read.valid) begin
                    // (R12) (R13) load or fail safe
                    d.dflash = cfg_read.dbit_fault ? `DF_FAILSAFE : cfg_read.data;
                    d.load = flash_protect_pkg::LOAD_DONE;
                    d.cfg_req = 1'b0;
                end
            end
            flash_protect_pkg::LOAD_DONE: begin
                d.cfg_req = 1'b0;
            end
        endcase

        // load complete flag registered for a clean output
        d.done = (d.load == flash_protect_pkg::LOAD_DONE);

        // check strobe is a one-cycle pulse
        d.chk_ctrl[`CHK_GO_BIT] = 1'b0;
        if (q.chk_ctrl[`CHK_GO_BIT] && refuse) begin
            d.refused = 1'b1;
            // (R14) violation set
            d.viol = 1'b1;
        end

        // register writes, only after the load completes
        if (req.wr && q.load == flash_protect_pkg::LOAD_DONE) begin
            unique case (req.addr)
                `ADDR_PFLASH_PROT: begin
                    // (R6) ignore whole write
                    if (allowed) begin
                        d.pflash = pf_cand;
                    end
                end
                `ADDR_DFLASH_PROT: begin
                    // (R9) size only grows
                    if (req.wdata[`DF_SIZE_MSB:`DF_SIZE_LSB]
                        > q.dflash[`DF_SIZE_MSB:`DF_SIZE_LSB]) begin
                        d.dflash[`DF_SIZE_MSB:`DF_SIZE_LSB] = req.wdata[`DF_SIZE_MSB:`DF_SIZE_LSB];
                    end
                    // (R10) disable only clears
                    if (!req.wdata[`DF_DIS_BIT]) begin
                        d.dflash[`DF_DIS_BIT] = 1'b0;
                    end
                end
                `ADDR_STATUS: begin
                    // write one clears, a new violation wins
                    if (req.wdata[`STAT_VIOL_BIT] && !d.refused) begin
                        d.viol = 1'b0;
                    end
                end
                `ADDR_CMD_INDEX: d.index = req.wdata[`CMD_IDX_W-1:0];
                `ADDR_CMD_HI: begin
                    // (R18) byte-wide high write
                    if (q.index < `CMD_IDX_W'(`CMD_WORDS)) begin
                        d.cmd[q.index][15:8] = req.wdata;
                    end
                end
                `ADDR_CMD_LO: begin
                    // (R18) byte-wide low write
                    if (q.index < `CMD_IDX_W'(`CMD_WORDS)) begin
                        d.cmd[q.index][7:0] = req.wdata;
                    end
                end
                `ADDR_CHECK_CTRL:    d.chk_ctrl = req.wdata[2:0];
                `ADDR_CHECK_ADDR_HI: d.chk_addr[17:16] = req.wdata[1:0];
                `ADDR_CHECK_ADDR_MID: d.chk_addr[15:8] = req.wdata;
                `ADDR_CHECK_ADDR_LO: d.chk_addr[7:0] = req.wdata;
                default: ;
            endcase
        end

        // register reads, data one cycle later
        if (req.rd) begin
            unique case (req.addr)
                // (R8) scenario in force
                `ADDR_PFLASH_PROT: d.rdata = q.pflash;
                `ADDR_DFLASH_PROT: d.rdata = {q.dflash[7], 3'h0, q.dflash[3:0]};
                `ADDR_STATUS:      d.rdata = {2'h0, q.viol, 5'h00};
                `ADDR_CMD_INDEX:   d.rdata = {5'h00, q.index};
                `ADDR_CMD_HI: begin
                    // (R18) unimplemented words read zero
                    d.rdata = (q.index < `CMD_IDX_W'(`CMD_WORDS)) ? q.cmd[q.index][15:8] : 8'h00;
                end
                `ADDR_CMD_LO: begin
                    d.rdata = (q.index < `CMD_IDX_W'(`CMD_WORDS)) ? q.cmd[q.index][7:0] : 8'h00;
                end
                `ADDR_CHECK_CTRL:     d.rdata = {5'h00, q.chk_ctrl[2:1], 1'b0};
                `ADDR_CHECK_ADDR_HI:  d.rdata = {6'h00, q.chk_addr[17:16]};
                `ADDR_CHECK_ADDR_MID: d.rdata = q.chk_addr[15:8];
                `ADDR_CHECK_ADDR_LO:  d.rdata = q.chk_addr[7:0];
                `ADDR_CHECK_RESULT:   d.rdata = {5'h00, df_any, pf_any, q.load == flash_protect_pkg::LOAD_DONE};
                default:              d.rdata = 8'h00;
            endcase
        end
    end

    // state register on the synchronised reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q.load     <= flash_protect_pkg::LOAD_PFLASH;
            q.done     <= 1'b0;
            q.cfg_req  <= 1'b0;
            q.cfg_addr <= 18'h00000;
            q.pflash   <= `REG_RESET;
            q.dflash   <= `REG_RESET;
            q.viol     <= 1'b0;
            q.index    <= '0;
            q.cmd      <= '0;
            q.chk_ctrl <= 3'h0;
            q.chk_addr <= 18'h00000;
            q.refused  <= 1'b0;
            q.rdata    <= 8'h00;
        end else begin
            q.load     <= d.load;
            q.done     <= d.done;
            q.cfg_req  <= d.cfg_req;
            q.cfg_addr <= d.cfg_addr;
            q.pflash   <= d.pflash;
            q.dflash   <= d.dflash;
            q.viol     <= d.viol;
            q.index    <= d.index;
            q.cmd      <= d.cmd;
            q.chk_ctrl <= d.chk_ctrl;
            q.chk_addr <= d.chk_addr;
            q.refused  <= d.refused;
            q.rdata    <= d.rdata;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata              = q.rdata;
    assign cfg_addr               = q.cfg_addr;
    assign cfg_req                = q.cfg_req;
    assign load_done              = q.done;
    assign check_refused          = q.refused;
    assign protect_violation_flag = q.viol;

endmodule : flash_protection_control
`default_nettype wire

// ---- flash_protection_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_cfg.svh"

module flash_protection_control_tb;
    logic                            mclk;
    logic                            nrst;
    logic [3:0]                      reg_addr;
    logic [7:0]                      reg_wdata;
    logic                            reg_wr;
    logic                            reg_rd;
    logic [7:0]                      reg_rdata;
    flash_protect_pkg::cfg_read_type cfg_read;
    logic [17:0]                     cfg_addr;
    logic                            cfg_req;
    logic                            load_done;
    logic                            check_refused;
    logic                            protect_violation_flag;
    int                              errors;
    int                              tests_run;
    logic [7:0]                      rv;

    flash_protection_control DUT (
        .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_read(cfg_read),
        .cfg_addr(cfg_addr), .cfg_req(cfg_req), .load_done(load_done),
        .check_refused(check_refused), .protect_violation_flag(protect_violation_flag)
    );

    // bus clock, 8 ns period
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        rv = reg_rdata;
        check(rv, exp, what);
    endtask : rdc

    // wait for a configuration request and answer it once
    task automatic answer(input logic [17:0] where, input logic [7:0] d, input logic f);
        int n;
        n = 0;
        while (cfg_req !== 1'b1 && n < 50) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check({7'h0, cfg_addr == where}, 8'h01, "config address");
        @(posedge mclk);
        cfg_read <= '{valid: 1'b1, addr: cfg_addr, data: d, dbit_fault: f};
        @(posedge mclk);
        cfg_read.valid <= 1'b0;
        #1;
    endtask : answer

    task automatic t_load(input logic [7:0] pd, input logic pf, input logic [7:0] dd,
                          input logic df, input logic [7:0] pexp, input logic [7:0] dexp);
        nrst <= 1'b0;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        answer(`CFG_ADDR_PFLASH, pd, pf);
        answer(`CFG_ADDR_DFLASH, dd, df);
        repeat (2) @(posedge mclk);
        #1;
        check({7'h0, load_done}, 8'h01, "load done");
        rdc(`ADDR_PFLASH_PROT, pexp, "program protection loaded");
        rdc(`ADDR_DFLASH_PROT, dexp, "data protection loaded");
        $display("test load finished");
    endtask : t_load

    // program a check address and request, then look at the refusal pulse
    task automatic probe(input logic [17:0] a, input logic [2:0] ctl, input logic exp);
        wr(`ADDR_CHECK_ADDR_HI, {6'h0, a[17:16]});
        wr(`ADDR_CHECK_ADDR_MID, a[15:8]);
        wr(`ADDR_CHECK_ADDR_LO, a[7:0]);
        wr(`ADDR_CHECK_CTRL, {5'h0, ctl});
        @(posedge mclk);
        #1;
        check({7'h0, check_refused}, {7'h0, exp}, "check refusal");
    endtask : probe

    // walk scenarios 7,6,(5),1,(2),3,(7) and probe the range edges of 6, 1 and 3
    task automatic t_scenarios;
        logic [7:0]  wv [6] = '{8'hEA, 8'hC4, 8'h5F, 8'h60, 8'h64, 8'hFF};
        logic [7:0]  ev [6] = '{8'hEA, 8'hEA, 8'h5E, 8'h5E, 8'h7C, 8'h7C};
        logic [17:0] pa [6] = '{18'h38FFF, 18'h39000, 18'h3C000, 18'h3BFFF, 18'h3FFFF, 18'h38000};
        logic        pr [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        for (int i = 0; i < 6; i++) begin
            wr(`ADDR_PFLASH_PROT, wv[i]);
            rdc(`ADDR_PFLASH_PROT, ev[i], "program scenario");
            probe(pa[i], 3'b001, pr[i]);
        end
        probe(18'h38000, 3'b101, 1'b1);
        $display("test program scenarios finished");
    endtask : t_scenarios

    task automatic t_dflash;
        logic [7:0] wv [5] = '{8'h82, 8'h85, 8'h05, 8'h85, 8'h06};
        logic [7:0] ev [5] = '{8'h83, 8'h85, 8'h05, 8'h05, 8'h06};
        probe(18'h04400, 3'b011, 1'b0);
        for (int i = 0; i < 5; i++) begin
            wr(`ADDR_DFLASH_PROT, wv[i]);
            rdc(`ADDR_DFLASH_PROT, ev[i], "data protection");
        end
        probe(18'h04AFF, 3'b011, 1'b1);
        probe(18'h04B00, 3'b011, 1'b0);
        probe(18'h04B00, 3'b111, 1'b1);
        $display("test data protection finished");
    endtask : t_dflash

    task automatic t_status;
        check({7'h0, protect_violation_flag}, 8'h01, "flag set");
        wr(`ADDR_STATUS, 8'h20);
        @(posedge mclk);
        #1;
        check({7'h0, protect_violation_flag}, 8'h00, "flag cleared");
        rdc(`ADDR_STATUS, 8'h00, "status bit after clear");
        probe(18'h04400, 3'b011, 1'b1);
        check({7'h0, protect_violation_flag}, 8'h01, "flag set again");
        $display("test status finished");
    endtask : t_status

    task automatic t_cmd;
        wr(`ADDR_CMD_INDEX, 8'h02);
        wr(`ADDR_CMD_HI, 8'hA5);
        wr(`ADDR_CMD_LO, 8'h3C);
        wr(`ADDR_CMD_INDEX, 8'h06);
        wr(`ADDR_CMD_HI, 8'hFF);
        rdc(`ADDR_CMD_HI, 8'h00, "unused command word");
        wr(`ADDR_CMD_INDEX, 8'h02);
        rdc(`ADDR_CMD_HI, 8'hA5, "command high byte");
        rdc(`ADDR_CMD_LO, 8'h3C, "command low byte");
        rdc(4'hF, 8'h00, "unmapped address");
        $display("test command words finished");
    endtask : t_cmd

    task automatic conclude;
        $display("tests %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // main sequence
    initial begin
        errors    = 0;
        tests_run = 0;
        nrst      = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        cfg_read  = '0;
        t_load(8'hFF, 1'b0, 8'h83, 1'b0, 8'hFF, 8'h83);
        t_scenarios;
        t_dflash;
        t_status;
        t_cmd;
        t_load(8'h00, 1'b1, 8'h00, 1'b1, `PF_FAILSAFE, `DF_FAILSAFE);
        rdc(`ADDR_CHECK_RESULT, 8'h07, "protection summary");
        conclude;
    end

    // watchdog well beyond the expected run length
    initial begin
        #40000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        conclude;
    end
endmodule : flash_protection_control_tb
`default_nettype wire

// ---- pflash_range_check.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_protect_cfg.svh"

// decides whether a program-flash address lies in a protected area
module pflash_range_check (
    input  wire logic [7:0]  prot_reg,
    input  wire logic [17:0] addr,
    output logic             protected_hit,
    output logic             any_protected
);
    logic        mode;
    logic        hdis;
    logic        ldis;
    logic [17:0] high_start;
    logic [17:0] low_end;
    logic        in_high;
    logic        in_low;

    // range bounds from the size codes
    always_comb begin
        mode = prot_reg[`PF_MODE_BIT];
        hdis = prot_reg[`PF_HDIS_BIT];
        ldis = prot_reg[`PF_LDIS_BIT];
        // (R3) high range size
        high_start = `PF_TOP + 18'h00001
            - (18'h00001 << (`HIGH_MIN_SHIFT + prot_reg[`PF_HSIZE_MSB:`PF_HSIZE_LSB]));
        // (R4) low range size
        low_end = `PF_BASE
            + (18'h00001 << (`LOW_MIN_SHIFT + prot_reg[`PF_LSIZE_MSB:`PF_LSIZE_LSB]));
        in_high = (addr >= high_start);
        in_low  = (addr >= `PF_BASE) && (addr < low_end);
        if (mode) begin
            // (R1) ranges protected
            protected_hit = (in_high && !hdis) || (in_low && !ldis);
            any_protected = !(hdis && ldis);
        end else begin
            // (R2) ranges unprotected
            protected_hit = !((in_high && !hdis) || (in_low && !ldis));
            any_protected = 1'b1;
        end
    end
endmodule : pflash_range_check
`default_nettype wire
